// file: verilog/wdt_cfg.svh
// wdt_cfg.svh: offsets, field positions, reset values and counts
// assumes: included by bare name from the watchdog design files
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
// register port
`define WDC_ADDR 16'hfe79
`define WDC_RESET 8'h00
`define WDC_CLEAR_KEY 8'h55
// field positions of the control register
`define WDC_FLAG_BIT 7
`define WDC_TEST_BIT 6
`define WDC_RUN_BIT 5
`define WDC_SBY_HI 4
`define WDC_SBY_LO 3
`define WDC_OVF_HI 2
`define WDC_OVF_LO 0
// counter
`define WD_CNT_W 17
`define WD_CNT_ONES 17'h1ffff
// reset values of the processor pointers
`define PC_RESET 16'h0000
`define SP_RESET 16'h0000
// system reset hold count in mclk cycles; the pulse lasts one cycle more
`define RST_HOLD_CYC 2'd2
`endif

// file: verilog/wdt_pkg.sv
// wdt_pkg.sv: types shared by the watchdog and reset-state logic
// assumes: nothing
package wdt_pkg;
    typedef enum logic [1:0] {
        SBY_COUNT = 2'b00,
        SBY_STOP = 2'b01,
        SBY_HOLD = 2'b10,
        SBY_COUNT2 = 2'b11
    } standby_mode_t;
    typedef enum logic [1:0] {
        CLK_MRC = 2'b00,
        CLK_MAIN = 2'b01
    } clk_src_t;
    typedef enum logic {
        RST_RUN = 1'b0,
        RST_HOLD = 1'b1
    } rst_state_t;
endpackage

// file: verilog/sync2.sv
// sync2.sv: two flip-flop synchroniser, one lane per bit
// assumes: inputs asynchronous to mclk; INIT is the idle level
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // lanes
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // sync2
`default_nettype wire

// file: verilog/wd_count.sv
// wd_count.sv: 17-bit watchdog up-counter with overflow select
// assumes: tick is one mclk cycle per low-speed oscillator rising edge
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module wd_count (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // control
    input wire logic run,
    input wire logic count_en,
    input wire logic clear,
    input wire logic tick,
    input wire logic [2:0] ovf_sel,
    // state
    output logic [16:0] count,
    output logic [16:0] limit,
    output logic ovf
);
    // last value before the selected count: 1023, 2047 ... 131071
    assign limit = `WD_CNT_ONES >> (3'd7 - ovf_sel);
    assign ovf = run && count_en && tick && (count == limit);
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count <= 17'h00000;
        end else if (!run || clear || ovf) begin
            count <= 17'h00000;
        end else if (count_en && tick) begin
            count <= count + 17'h00001;
        end
    end
endmodule // wd_count
`default_nettype wire

// file: verilog/watchdog_and_reset_state.sv
// watchdog_and_reset_state.sv: watchdog timer and system reset state
// assumes: one mclk domain; pins and the slow oscillator are sampled
//
// Contract
// (R01) External reset pin low for 200 us or more guarantees reset.
// (R02) Every reset source yields a reset synchronised to the system clock.
// (R03) Any reset selects the medium-speed RC oscillator as system clock.
// (R04) Main clock is selected only after its stabilisation is secured.
// (R05) Reset loads the program counter with zero.
// (R06) Reset loads the stack pointer with zero.
// (R07) Reset never clears data RAM.
// (R08) 17-bit up-counter on the slow oscillator, counting only while run set.
// (R09) Overflow at the selected count: 1024 doubling up to 131072.
// (R10) Overflow raises chip reset, clears run, sets the reset flag.
// (R11) Pin or power reset loads 00; watchdog reset keeps bits 4 to 0.
// (R12) Flag clears on pin or power reset, sets on watchdog reset, writable.
// (R13) Writes to the control register are ignored while run is set.
// (R14) Only the move-immediate write of 55 clears and restarts the counter.
// (R15) Run bit written 1 starts the watchdog, 0 stops it; here a 0 written while run is set is ignored.
// (R16) Counter held at zero while run is 0.
// (R17) Standby field: 00 count, 01 suspend, 10 hold count, 11 count.
// (R18) Software always writes 0 to the test bit.
// (R19) Slow oscillator runs when run set or slow system select set.
// (R20) Watchdog keeps counting although the system clock stops.
// (R21) Standby with suspend setting stops watchdog and clears run.
// (R22) Hold setting stops oscillator and freezes count during standby.
// (R23) Run, clear and overflow cross oscillator and system domains safely.
// (R24) Watchdog reset held at least one full system clock cycle.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module watchdog_and_reset_state (
    // clock and power-on reset
    input wire logic mclk,
    input wire logic reset,
    // reset and oscillator pins
    input wire logic ext_reset_pin_n,
    input wire logic low_voltage_reset,
    input wire logic lsrc_clk,
    input wire logic main_osc_stable,
    // processor status
    input wire logic standby_active,
    input wire logic slow_osc_sys_select,
    input wire logic main_clk_req,
    input wire logic mov_imm_wr,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // reset state outputs
    output logic sys_reset,
    output logic [15:0] pc_init,
    output logic [15:0] sp_init,
    output logic ram_wr_inhibit,
    output logic [1:0] clk_src_sel,
    output logic lsrc_osc_en,
    output logic [16:0] wd_counter
);
    // ==========================================================
    // pin synchronisers
    // ==========================================================
    logic ext_n_s;
    logic lvd_s;
    logic lsrc_s;
    logic stable_s;
    logic lsrc_d;
    logic tick;

    sync2 #(
        .W(4),
        .INIT(4'h8)
    ) u_pin_sync (
        .mclk(mclk),
        .reset(reset),
        .d({ext_reset_pin_n, low_voltage_reset, lsrc_clk, main_osc_stable}),
        .q({ext_n_s, lvd_s, lsrc_s, stable_s})
    );

    // oscillator edge seen after the synchroniser only
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lsrc_d <= 1'b0;
        end else begin
            lsrc_d <= lsrc_s; // R23
        end
    end
    assign tick = lsrc_s & ~lsrc_d; // R08 R20

    // ==========================================================
    // control register fields
    // ==========================================================
    logic flag;
    logic test_bit_zero;
    logic run;
    logic [1:0] standby_sel;
    logic [2:0] ovf_sel;
    logic [7:0] ctl_word;
    logic hit;
    logic cold_req;
    logic ovf;
    logic wd_clear;
    logic count_en;
    logic sby_stop;
    logic sby_hold;
    logic [16:0] limit;
    logic ctl_write;
    logic [1:0] hold_cnt;
    wdt_pkg::rst_state_t rst_state;

    // ==========================================================
    // register decode
    // ==========================================================
    always_comb begin
        hit = 1'b0;
        if (reg_addr == `WDC_ADDR) begin
            hit = 1'b1;
        end
    end

    // ordinary writes only while the watchdog is stopped
    assign ctl_write = hit && reg_wr && !run && !sys_reset; // R13 R15
    // clear key honoured only from the move-immediate path
    assign wd_clear = hit && reg_wr && mov_imm_wr && run && !sys_reset
        && (reg_wdata == `WDC_CLEAR_KEY); // R14
    // pin low or low-voltage detect: a cold reset request
    assign cold_req = ~ext_n_s | lvd_s; // R02 R11
    assign ctl_word = {flag, test_bit_zero, run, standby_sel, ovf_sel};

    // ==========================================================
    // standby behaviour
    // ==========================================================
    assign sby_stop = standby_active && (standby_sel == wdt_pkg::SBY_STOP); // R17 R21
    assign sby_hold = standby_active && (standby_sel == wdt_pkg::SBY_HOLD); // R17 R22
    // modes 00 and 11 keep counting through standby
    assign count_en = ~sby_hold; // R17 R20

    // ==========================================================
    // reset detection flag
    // ==========================================================
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flag <= 1'b0;
        end else if (cold_req) begin
            flag <= 1'b0; // R12
        end else if (ovf) begin
            flag <= 1'b1; // R10 R12
        end else if (ctl_write) begin
            flag <= reg_wdata[`WDC_FLAG_BIT]; // R12
        end
    end

    // ==========================================================
    // run bit
    // ==========================================================
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            run <= 1'b0;
        end else if (cold_req) begin
            run <= 1'b0; // R11
        end else if (ovf) begin
            run <= 1'b0; // R10
        end else if (sby_stop) begin
            run <= 1'b0; // R21
        end else if (ctl_write) begin
            run <= reg_wdata[`WDC_RUN_BIT]; // R15
        end
    end

    // ==========================================================
    // low fields, kept through a watchdog reset
    // ==========================================================
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            test_bit_zero <= 1'b0;
            standby_sel <= 2'h0;
            ovf_sel <= 3'h0;
        end else if (cold_req) begin
            test_bit_zero <= 1'b0;
            standby_sel <= 2'h0;
            ovf_sel <= 3'h0; // R11
        end else if (ctl_write) begin
            test_bit_zero <= reg_wdata[`WDC_TEST_BIT];
            standby_sel <= reg_wdata[`WDC_SBY_HI:`WDC_SBY_LO]; // R17
            ovf_sel <= reg_wdata[`WDC_OVF_HI:`WDC_OVF_LO]; // R09
        end
    end

    // ==========================================================
    // watchdog counter
    // ==========================================================
    // synchronised oscillator edge drives one count step
    wd_count u_wd_count (
        .mclk(mclk),
        .reset(reset),
        .run(run), // R08 R16
        .count_en(count_en), // R22
        .clear(wd_clear), // R14
        .tick(tick), // R08
        .ovf_sel(ovf_sel), // R09
        .count(wd_counter),
        .limit(limit), // R09
        .ovf(ovf) // R10
    );

    // ==========================================================
    // slow oscillator enable
    // ==========================================================
    // stopped by reset and by hold-count standby unless slow system select is set
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lsrc_osc_en <= 1'b0; // R19
        end else begin
            lsrc_osc_en <= (run && !sby_hold) || slow_osc_sys_select; // R19 R22
        end
    end

    // ==========================================================
    // system reset sequencer
    // ==========================================================
    // every source is stretched and released on mclk
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rst_state <= wdt_pkg::RST_HOLD;
            hold_cnt <= `RST_HOLD_CYC;
        end else begin
            case (rst_state)
                wdt_pkg::RST_RUN: begin
                    if (cold_req || ovf) begin
                        rst_state <= wdt_pkg::RST_HOLD; // R02 R10
                        hold_cnt <= `RST_HOLD_CYC; // R24
                    end
                end
                wdt_pkg::RST_HOLD: begin
                    if (cold_req || ovf) begin
                        hold_cnt <= `RST_HOLD_CYC;
                    end else if (hold_cnt != 2'h0) begin
                        hold_cnt <= hold_cnt - 2'h1; // R24
                    end else begin
                        rst_state <= wdt_pkg::RST_RUN;
                    end
                end
                default: begin
                    rst_state <= wdt_pkg::RST_HOLD;
                end
            endcase
        end
    end
    assign sys_reset = (rst_state == wdt_pkg::RST_HOLD); // R02
    // ram keeps its contents: writes blocked, never cleared
    assign ram_wr_inhibit = sys_reset; // R07

    // ==========================================================
    // reset-state outputs
    // ==========================================================
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pc_init <= `PC_RESET; // R05
            sp_init <= `SP_RESET; // R06
        end else if (sys_reset) begin
            pc_init <= `PC_RESET;
            sp_init <= `SP_RESET;
        end
    end

    // main clock only once its oscillator is reported stable
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            clk_src_sel <= wdt_pkg::CLK_MRC; // R03
        end else if (sys_reset) begin
            clk_src_sel <= wdt_pkg::CLK_MRC; // R03
        end else if (main_clk_req && stable_s) begin
            clk_src_sel <= wdt_pkg::CLK_MAIN; // R04
        end else begin
            clk_src_sel <= wdt_pkg::CLK_MRC;
        end
    end

    // ==========================================================
    // register read
    // ==========================================================
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && hit) begin
            reg_rdata <= ctl_word;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // assertions
    // ==========================================================
    a_write_lock: assert property (@(posedge mclk) disable iff (reset) // R13
        (run && !cold_req) |=> (ctl_word[4:0] == $past(ctl_word[4:0])))
        else $error("control fields changed while the watchdog ran");

    a_ovf_flag: assert property (@(posedge mclk) disable iff (reset) // R10
        (ovf && !cold_req) |=> (flag && !run))
        else $error("overflow did not set the flag and clear run");

    a_ovf_reset: assert property (@(posedge mclk) disable iff (reset) // R10
        ovf |=> sys_reset)
        else $error("overflow did not raise the system reset");

    a_reset_min: assert property (@(posedge mclk) disable iff (reset) // R24
        $rose(sys_reset) |=> sys_reset)
        else $error("system reset shorter than two cycles");

    a_idle_zero: assert property (@(posedge mclk) disable iff (reset) // R16
        !run |=> (wd_counter == 17'h00000))
        else $error("counter not zero while stopped");

    a_clear_zero: assert property (@(posedge mclk) disable iff (reset) // R14
        wd_clear |=> (wd_counter == 17'h00000))
        else $error("clear key did not zero the counter");

    a_hold_freeze: assert property (@(posedge mclk) disable iff (reset) // R22
        (sby_hold && run && !wd_clear) |=> (wd_counter == $past(wd_counter)))
        else $error("counter moved in hold-count standby");

    a_stop_clears: assert property (@(posedge mclk) disable iff (reset) // R21
        sby_stop |=> !run)
        else $error("suspend standby left run set");

    a_reset_mrc: assert property (@(posedge mclk) disable iff (reset) // R03
        sys_reset |=> (clk_src_sel == wdt_pkg::CLK_MRC))
        else $error("reset did not select the medium-speed oscillator");

    a_main_stable: assert property (@(posedge mclk) disable iff (reset) // R04
        !stable_s |=> (clk_src_sel == wdt_pkg::CLK_MRC))
        else $error("main clock selected before it was stable");

    a_osc_in_hold: assert property (@(posedge mclk) disable iff (reset) // R22
        (sby_hold && !slow_osc_sys_select) |=> !lsrc_osc_en)
        else $error("slow oscillator left running in hold standby");

    c_overflow: cover property (@(posedge mclk) disable iff (reset) ovf);
    c_clear_key: cover property (@(posedge mclk) disable iff (reset) wd_clear);
    c_hold_standby: cover property (@(posedge mclk) disable iff (reset) sby_hold && run);
    c_cold_reset: cover property (@(posedge mclk) disable iff (reset) cold_req);
endmodule // watchdog_and_reset_state
`default_nettype wire

// file: verif/test_watchdog_and_reset_state.sv
// test_watchdog_and_reset_state.sv: self-checking bench for the watchdog block
// assumes: design files from verilog/ compiled first; mclk samples lsrc_clk
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module test_watchdog_and_reset_state;
    logic mclk = 1'b0, reset = 1'b1, ext_reset_pin_n = 1'b1, lsrc_clk = 1'b0;
    logic main_osc_stable = 1'b0, main_clk_req = 1'b1, mov_imm_wr = 1'b0;
    logic low_voltage_reset = 1'b0, standby_active = 1'b0, slow_osc_sys_select = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, sys_reset, ram_wr_inhibit, lsrc_osc_en;
    logic [15:0] reg_addr = `WDC_ADDR, pc_init, sp_init;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [1:0] clk_src_sel;
    logic [16:0] wd_counter;
    logic [16:0] held;
    logic [7:0] rows [4] = '{8'h00, 8'h1f, 8'h9a, 8'h87};
    int fail_count = 0, total_checks = 0, n, m;
    watchdog_and_reset_state u_watchdog_and_reset_state (.mclk, .reset, .ext_reset_pin_n,
        .low_voltage_reset, .lsrc_clk, .main_osc_stable, .standby_active, .slow_osc_sys_select,
        .main_clk_req, .mov_imm_wr, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .sys_reset, .pc_init, .sp_init, .ram_wr_inhibit, .clk_src_sel, .lsrc_osc_en,
        .wd_counter);
    // =======================================
    // clocks; slow oscillator only while enabled
    initial forever #5 mclk = ~mclk;
    initial forever begin
        #17;
        if (lsrc_osc_en === 1'b1) lsrc_clk = ~lsrc_clk;
    end
    // =======================================
    // bus tasks and compare
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrc(input logic [7:0] d, input logic mv);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_wdata <= d;
        mov_imm_wr <= mv;
        @(posedge mclk);
        reg_wr <= 1'b0;
        mov_imm_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk({9'h000, reg_rdata}, {9'h000, exp});
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #600000;
        fail_count++;
        close_out();
    end
    // =======================================
    // test sequence
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        rdc(`WDC_RESET);
        chk({1'b0, pc_init}, {1'b0, `PC_RESET});
        chk({1'b0, sp_init}, {1'b0, `SP_RESET});
        chk({15'h0000, clk_src_sel}, {15'h0000, wdt_pkg::CLK_MRC});
        chk({16'h0000, ram_wr_inhibit}, 17'h00000);
        $display("reset test done");
        foreach (rows[i]) begin
            wrc(rows[i], 1'b0);
            rdc(rows[i]);
        end
        $display("row test done");
        main_osc_stable <= 1'b1;
        repeat (8) @(posedge mclk);
        chk({15'h0000, clk_src_sel}, {15'h0000, wdt_pkg::CLK_MAIN});
        wrc(8'h28, 1'b0);
        wrc(8'h00, 1'b0);
        rdc(8'h28);
        chk(lsrc_osc_en, 1'b1);
        repeat (200) @(posedge mclk);
        wrc(`WDC_CLEAR_KEY, 1'b0);
        @(negedge mclk);
        chk(wd_counter > 17'd16, 1'b1);
        wrc(`WDC_CLEAR_KEY, 1'b1);
        @(negedge mclk);
        chk(wd_counter < 17'd8, 1'b1);
        n = 0;
        while (sys_reset !== 1'b1 && n < 6000) begin
            @(negedge mclk);
            n++;
        end
        chk(n > 1500 && n < 6000, 1'b1);
        m = 0;
        while (sys_reset === 1'b1 && m < 50) begin
            @(negedge mclk);
            m++;
        end
        chk(m >= 1 && m < 50, 1'b1);
        repeat (3) @(posedge mclk);
        rdc(8'h88);
        chk(wd_counter, 17'h0);
        $display("overflow test done");
        ext_reset_pin_n <= 1'b0;
        repeat (100) @(posedge mclk);
        chk(sys_reset, 1'b1);
        chk({15'h0000, clk_src_sel}, {15'h0000, wdt_pkg::CLK_MRC});
        chk({16'h0000, ram_wr_inhibit}, 17'h00001);
        repeat (19900) @(posedge mclk);
        ext_reset_pin_n <= 1'b1;
        repeat (20) @(posedge mclk);
        rdc(8'h00);
        $display("pin reset test done");
        wrc(8'h30, 1'b0);
        repeat (100) @(posedge mclk);
        standby_active <= 1'b1;
        repeat (4) @(negedge mclk);
        chk(lsrc_osc_en, 1'b0);
        held = wd_counter;
        repeat (100) @(negedge mclk);
        chk(wd_counter, held);
        chk(held > 17'd4, 1'b1);
        @(posedge mclk);
        standby_active <= 1'b0;
        repeat (100) @(negedge mclk);
        chk(wd_counter > held, 1'b1);
        $display("hold standby test done");
        @(posedge mclk);
        low_voltage_reset <= 1'b1;
        repeat (6) @(negedge mclk);
        chk(sys_reset, 1'b1);
        chk({16'h0000, ram_wr_inhibit}, 17'h00001);
        @(posedge mclk);
        low_voltage_reset <= 1'b0;
        repeat (10) @(posedge mclk);
        rdc(8'h00);
        chk(wd_counter, 17'h0);
        $display("low voltage reset test done");
        wrc(8'h28, 1'b0);
        standby_active <= 1'b1;
        repeat (3) @(posedge mclk);
        rdc(8'h08);
        chk(lsrc_osc_en, 1'b0);
        chk(wd_counter, 17'h0);
        @(posedge mclk);
        standby_active <= 1'b0;
        slow_osc_sys_select <= 1'b1;
        repeat (3) @(negedge mclk);
        chk(lsrc_osc_en, 1'b1);
        $display("suspend standby test done");
        close_out();
    end
endmodule // test_watchdog_and_reset_state
`default_nettype wire
